// File: mcu_decode_pkg.sv
`default_nettype none
package mcu_decode_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int TIMER_MIN_PERIOD_NS = 80000;
    localparam logic [11:0] TIMER_TICK_CYCLES =
        12'((TIMER_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int STACK_DEPTH = 8;

    localparam logic [2:0] IDX_CMD = 3'h0;
    localparam logic [2:0] IDX_ACC = 3'h1;
    localparam logic [2:0] IDX_PROG = 3'h2;
    localparam logic [2:0] IDX_STATUS = 3'h3;
    localparam logic [2:0] IDX_TIMER = 3'h4;

    localparam int ST_UBF = 8;
    localparam int ST_EXT_EN = 9;
    localparam int ST_CNT_EN = 10;
    localparam int ST_TOF = 11;
    localparam int ST_PEND = 12;
    localparam int ST_RUN_BIT = 13;
    localparam int ST_EVT = 14;
    localparam int ST_CLKO = 15;
    localparam int ST_INSVC = 16;

    localparam logic [7:0] PORT_RESET = 8'hff;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [11:0] PROG_RESET = 12'h000;

    localparam logic [7:0] OP_IDLE = 8'h00;
    localparam logic [7:0] OP_BUS_OUT = 8'h02;
    localparam logic [7:0] OP_ADD_IMM = 8'h03;
    localparam logic [7:0] OP_EXT_ON = 8'h05;
    localparam logic [7:0] OP_BUS_IN = 8'h08;
    localparam logic [7:0] OP_ADD_WITH_CARRY_IMM = 8'h13;
    localparam logic [7:0] OP_EXT_OFF = 8'h15;
    localparam logic [7:0] OP_JUMP_TOF = 8'h16;
    localparam logic [7:0] OP_CNT_ON = 8'h25;
    localparam logic [7:0] OP_CNT_OFF = 8'h35;
    localparam logic [7:0] OP_TMR_RD = 8'h42;
    localparam logic [7:0] OP_EVT_START = 8'h45;
    localparam logic [7:0] OP_TMR_START = 8'h55;
    localparam logic [7:0] OP_DEC_ADJ = 8'h57;
    localparam logic [7:0] OP_TMR_WR = 8'h62;
    localparam logic [7:0] OP_HALT = 8'h65;
    localparam logic [7:0] OP_CLK_OUT = 8'h75;
    localparam logic [7:0] OP_POP_ONLY = 8'h83;
    localparam logic [7:0] OP_BUS_OR = 8'h88;
    localparam logic [7:0] OP_POP_FLAGS = 8'h93;
    localparam logic [7:0] OP_BUS_AND = 8'h98;
    localparam logic [7:0] OP_RBANK0 = 8'hc5;
    localparam logic [7:0] OP_RBANK1 = 8'hd5;
    localparam logic [7:0] OP_MBANK0 = 8'he5;
    localparam logic [7:0] OP_MBANK1 = 8'hf5;
    localparam logic [4:0] CALL_LOW = 5'h14;
    localparam logic [5:0] GRP_P_IN = 6'h02;
    localparam logic [5:0] GRP_P_OUT = 6'h0e;
    localparam logic [5:0] GRP_P_AND = 6'h26;
    localparam logic [5:0] GRP_P_OR = 6'h22;
    localparam logic [5:0] GRP_N_IN = 6'h03;
    localparam logic [5:0] GRP_N_OUT = 6'h0f;
    localparam logic [5:0] GRP_N_AND = 6'h27;
    localparam logic [5:0] GRP_N_OR = 6'h23;

    localparam logic [1:0] EXP_READ = 2'h0;
    localparam logic [1:0] EXP_WRITE = 2'h1;
    localparam logic [1:0] EXP_OR = 2'h2;
    localparam logic [1:0] EXP_AND = 2'h3;

    typedef struct packed {
        logic [11:0] pc;
        logic [3:0] flags;
    } stack_entry_s;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } qport_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DONE = 2'b10
    } exec_state_e;
endpackage
`default_nettype wire

// File: mcu_call_io_timer_decode.sv
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Call pushes return address and flags, jumps
// - Plain pop restores address only
// - Flag pop restores address, flags, reenables interrupts
// - Port read copies pins to accumulator
// - Port write latches accumulator
// - Port mask AND/OR with immediate
// - Bus read into accumulator
// - Bus write latches accumulator
// - Bus mask AND/OR with immediate
// - Nibble read, upper accumulator bits zero
// - Nibble write of low accumulator bits
// - Nibble AND/OR left in expander port
// - Register bank select clear/set
// - Memory bank flag feeds address bit 11
// - Enable clock output on test pin zero
// - Counter read and load, one cycle
// - Timer mode, 80 us count period
// - Event mode counts test pin one rises
// - Halt stops either counting mode
// - Counter irq enable; disable clears pending
// - Idle op only advances address, one cycle
// - Carry and half carry from add, adjust
// - Overflow flag cleared by its jump
module mcu_call_io_timer_decode
    import mcu_decode_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] port1_in,
    output var mcu_decode_pkg::qport_s port1_drv,
    input wire logic [7:0] port2_in,
    output var mcu_decode_pkg::qport_s port2_drv,
    input wire logic [7:0] bus_in,
    output logic [7:0] bus_out,
    output logic bus_oe,
    input wire logic [3:0] exp_in,
    output logic [3:0] exp_out,
    output logic [1:0] exp_cmd,
    output logic [1:0] exp_port,
    output logic exp_strobe,
    output logic test_input_zero_out,
    output logic test_input_zero_oe,
    input wire logic test_input_one,
    output logic counter_irq,
    output logic ext_irq_enable,
    output logic reg_bank,
    output logic irq_blocked
);
    import mcu_decode_pkg::*;

    exec_state_e state_reg, state_next;
    logic [7:0] op_reg, imm_reg, acc_reg, acc_next;
    logic cyc_reg;
    logic [11:0] program_counter_reg, pc_next;
    logic [3:0] status_word_reg, status_next;
    logic [2:0] stack_pointer_reg, sp_next;
    logic upper_bank_flag_reg, ubf_next;
    logic ext_irq_enable_flag_reg, ext_next;
    logic counter_irq_enable_flag_reg, cnt_en_next;
    logic timer_overflow_flag_reg, pend_reg, insvc_reg, insvc_next;
    logic run_reg, run_next, evt_reg, evt_next, clko_reg, clko_next;
    logic [7:0] timer_reg, timer_next, p1_reg, p1_next, p2_reg, p2_next;
    logic [7:0] bus_reg, bus_next;
    logic bus_oe_reg, bus_oe_next, t1_prev_reg, div_reg, rd_ack_reg;
    logic [11:0] presc_reg, presc_next;
    logic [31:0] rd_data_reg;
    logic tof_clr, pend_clr;
    stack_entry_s stack_mem [STACK_DEPTH];

    wire [2:0] idx = avs_address[4:2];
    wire cmd_sel = idx == IDX_CMD;
    wire sw_wr = avs_write && !cmd_sel;
    wire first = state_reg == ST_EXEC && !cyc_reg;
    wire [5:0] grp = op_reg[7:2];
    wire [1:0] psel = op_reg[1:0];
    wire port_ok = psel == 2'd1 || psel == 2'd2;
    wire is_call = op_reg[4:0] == CALL_LOW;
    wire is_pop = op_reg == OP_POP_ONLY || op_reg == OP_POP_FLAGS;
    wire is_p_in = grp == GRP_P_IN && port_ok;
    wire is_p_out = grp == GRP_P_OUT && port_ok;
    wire is_p_and = grp == GRP_P_AND && port_ok;
    wire is_p_or = grp == GRP_P_OR && port_ok;
    wire is_p_mask = is_p_and || is_p_or;
    wire is_b_mask = op_reg == OP_BUS_AND || op_reg == OP_BUS_OR;
    wire is_nib = grp == GRP_N_IN || grp == GRP_N_OUT
        || grp == GRP_N_AND || grp == GRP_N_OR;
    wire is_add = op_reg == OP_ADD_IMM || op_reg == OP_ADD_WITH_CARRY_IMM;
    wire two_byte = is_call || is_p_mask || is_b_mask || is_add
        || op_reg == OP_JUMP_TOF;
    wire two_cycle = two_byte || is_pop || is_p_in || is_p_out || is_nib
        || op_reg == OP_BUS_IN || op_reg == OP_BUS_OUT;
    wire exec = state_reg == ST_EXEC && cyc_reg == two_cycle;
    wire tmr_load = exec && op_reg == OP_TMR_WR;
    wire [11:0] pc_adv = program_counter_reg + (two_byte ? 12'd2 : 12'd1);
    wire [2:0] sp_dec = stack_pointer_reg - 3'd1;
    wire stack_entry_s top = stack_mem[sp_dec];
    wire [7:0] port_latch = psel == 2'd1 ? p1_reg : p2_reg;
    wire [7:0] port_pins = psel == 2'd1 ? port1_in : port2_in;
    wire [7:0] bus_masked = op_reg == OP_BUS_AND ? bus_reg & imm_reg
        : bus_reg | imm_reg;
    wire [7:0] port_masked = is_p_and ? port_latch & imm_reg
        : port_latch | imm_reg;

    // Carry chain for add and decimal adjust
    wire cin = op_reg == OP_ADD_WITH_CARRY_IMM && status_word_reg[3];
    wire [8:0] sum9 = {1'b0, acc_reg} + {1'b0, imm_reg} + {8'h00, cin};
    wire [4:0] half5 = {1'b0, acc_reg[3:0]} + {1'b0, imm_reg[3:0]}
        + {4'h0, cin};
    wire lo_adj = acc_reg[3:0] > 4'h9 || status_word_reg[2];
    wire [4:0] adj_lo5 = {1'b0, acc_reg[3:0]} + (lo_adj ? 5'h06 : 5'h00);
    wire [8:0] adj1 = {1'b0, acc_reg} + (lo_adj ? 9'h006 : 9'h000);
    wire hi_adj = adj1[7:4] > 4'h9 || status_word_reg[3] || adj1[8];
    wire [8:0] adj2 = {1'b0, adj1[7:0]} + (hi_adj ? 9'h060 : 9'h000);

    // Timer and event counting
    wire timer_tick = run_reg && !evt_reg
        && presc_reg == TIMER_TICK_CYCLES - 12'd1;
    wire event_tick = run_reg && evt_reg && test_input_one
        && !t1_prev_reg;
    wire count_up = (timer_tick || event_tick) && !tmr_load;
    wire overflow = count_up && timer_reg == 8'hff;
    wire tof_next = (timer_overflow_flag_reg && !tof_clr) || overflow;
    wire pend_next = (pend_reg && !pend_clr)
        || (overflow && counter_irq_enable_flag_reg);

    wire [7:0] status_word = {status_word_reg, 1'b1, stack_pointer_reg};
    wire [16:0] status_bits = {insvc_reg, clko_reg, evt_reg, run_reg,
        pend_reg, timer_overflow_flag_reg, counter_irq_enable_flag_reg,
        ext_irq_enable_flag_reg, upper_bank_flag_reg, status_word};
    wire [31:0] rd_mux =
        idx == IDX_CMD ? {16'h0000, imm_reg, op_reg} :
        idx == IDX_ACC ? {24'h000000, acc_reg} :
        idx == IDX_PROG ? {20'h00000, program_counter_reg} :
        idx == IDX_STATUS ? {15'h0000, status_bits} :
        idx == IDX_TIMER ? {24'h000000, timer_reg} : 32'h00000000;

    assign avs_waitrequest = (avs_write && cmd_sel && state_reg != ST_DONE)
        || (avs_read && !rd_ack_reg);
    assign avs_readdata = rd_data_reg;
    assign port1_drv.out = p1_reg;
    assign port1_drv.oe = ~p1_reg;
    assign port2_drv.out = p2_reg;
    assign port2_drv.oe = ~p2_reg;
    assign bus_out = bus_reg;
    assign bus_oe = bus_oe_reg;
    assign exp_strobe = first && is_nib;
    assign exp_port = psel;
    assign exp_out = acc_reg[3:0];
    assign exp_cmd = grp == GRP_N_OUT ? EXP_WRITE : grp == GRP_N_AND
        ? EXP_AND : grp == GRP_N_OR ? EXP_OR : EXP_READ;
    assign test_input_zero_out = div_reg;
    assign test_input_zero_oe = clko_reg;
    assign counter_irq = pend_reg;
    assign ext_irq_enable = ext_irq_enable_flag_reg;
    assign reg_bank = status_word_reg[0];
    assign irq_blocked = insvc_reg;
    assign presc_next = (!run_reg || evt_reg || timer_tick)
        ? 12'h000 : presc_reg + 12'd1;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
                if (avs_write && cmd_sel)
                    state_next = ST_EXEC;
            ST_EXEC:
                if (exec)
                    state_next = ST_DONE;
            ST_DONE:
                state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    always_comb
    begin
        acc_next = acc_reg;
        pc_next = program_counter_reg;
        status_next = status_word_reg;
        sp_next = stack_pointer_reg;
        ubf_next = upper_bank_flag_reg;
        ext_next = ext_irq_enable_flag_reg;
        cnt_en_next = counter_irq_enable_flag_reg;
        insvc_next = insvc_reg;
        run_next = run_reg;
        evt_next = evt_reg;
        clko_next = clko_reg;
        p1_next = p1_reg;
        p2_next = p2_reg;
        bus_next = bus_reg;
        bus_oe_next = bus_oe_reg;
        timer_next = count_up ? timer_reg + 8'd1 : timer_reg;
        tof_clr = 1'b0;
        pend_clr = 1'b0;
        if (sw_wr && idx == IDX_ACC)
            acc_next = avs_writedata[7:0];
        if (sw_wr && idx == IDX_PROG)
            pc_next = avs_writedata[11:0];
        if (sw_wr && idx == IDX_STATUS)
        begin
            status_next = avs_writedata[7:4];
            insvc_next = avs_writedata[ST_INSVC];
        end
        if (first && op_reg == OP_BUS_IN)
            bus_oe_next = 1'b0;
        if (exec)
        begin
            pc_next = pc_adv;
            if (is_call)
            begin
                sp_next = stack_pointer_reg + 3'd1;
                pc_next = {upper_bank_flag_reg, op_reg[7:5],
                    imm_reg};
            end
            if (is_pop)
            begin
                sp_next = sp_dec;
                pc_next = top.pc;
            end
            if (op_reg == OP_POP_FLAGS)
            begin
                status_next = top.flags;
                insvc_next = 1'b0;
            end
            if (is_p_in)
                acc_next = port_pins;
            if (is_p_out || is_p_mask)
            begin
                if (psel == 2'd1)
                    p1_next = is_p_out ? acc_reg : port_masked;
                else
                    p2_next = is_p_out ? acc_reg : port_masked;
            end
            if (op_reg == OP_BUS_IN)
                acc_next = bus_in;
            if (op_reg == OP_BUS_OUT || is_b_mask)
            begin
                bus_oe_next = 1'b1;
                bus_next = is_b_mask ? bus_masked : acc_reg;
            end
            if (grp == GRP_N_IN)
                acc_next = {4'h0, exp_in};
            if (is_add)
            begin
                acc_next = sum9[7:0];
                status_next[3] = sum9[8];
                status_next[2] = half5[4];
            end
            if (op_reg == OP_DEC_ADJ)
            begin
                acc_next = adj2[7:0];
                status_next[3] = adj1[8] || adj2[8];
                status_next[2] = adj_lo5[4];
            end
            if (op_reg == OP_JUMP_TOF)
            begin
                tof_clr = 1'b1;
                if (timer_overflow_flag_reg)
                    pc_next = {pc_adv[11:8], imm_reg};
            end
            if (op_reg == OP_EXT_ON)
                ext_next = 1'b1;
            if (op_reg == OP_EXT_OFF)
                ext_next = 1'b0;
            if (op_reg == OP_RBANK0 || op_reg == OP_RBANK1)
                status_next[0] = op_reg[4];
            if (op_reg == OP_MBANK0 || op_reg == OP_MBANK1)
                ubf_next = op_reg[4];
            if (op_reg == OP_CLK_OUT)
                clko_next = 1'b1;
            if (op_reg == OP_TMR_RD)
                acc_next = timer_reg;
            if (tmr_load)
                timer_next = acc_reg;
            if (op_reg == OP_TMR_START || op_reg == OP_EVT_START)
            begin
                run_next = 1'b1;
                evt_next = op_reg == OP_EVT_START;
            end
            if (op_reg == OP_HALT)
                run_next = 1'b0;
            if (op_reg == OP_CNT_ON)
                cnt_en_next = 1'b1;
            if (op_reg == OP_CNT_OFF)
            begin
                cnt_en_next = 1'b0;
                pend_clr = 1'b1;
            end
        end
    end

    // Stack storage
    always_ff @(posedge clk)
    begin
        if (exec && is_call)
            stack_mem[stack_pointer_reg] <= {pc_adv, status_word_reg};
    end

    // Bus slave and sequencing
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_IDLE;
            cyc_reg <= 1'b0;
            op_reg <= OP_IDLE;
            imm_reg <= 8'h00;
            rd_ack_reg <= 1'b0;
            rd_data_reg <= 32'h00000000;
        end
        else
        begin
            state_reg <= state_next;
            cyc_reg <= state_reg == ST_EXEC && !exec;
            if (state_reg == ST_IDLE && avs_write && cmd_sel)
            begin
                op_reg <= avs_writedata[7:0];
                imm_reg <= avs_writedata[15:8];
            end
            rd_ack_reg <= avs_read && !rd_ack_reg;
            if (avs_read && !rd_ack_reg)
                rd_data_reg <= rd_mux;
        end
    end

    // Architectural state
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            acc_reg <= ACC_RESET;
            program_counter_reg <= PROG_RESET;
            status_word_reg <= 4'h0;
            stack_pointer_reg <= 3'h0;
            upper_bank_flag_reg <= 1'b0;
            ext_irq_enable_flag_reg <= 1'b0;
            counter_irq_enable_flag_reg <= 1'b0;
            insvc_reg <= 1'b0;
            p1_reg <= PORT_RESET;
            p2_reg <= PORT_RESET;
            bus_reg <= 8'h00;
            bus_oe_reg <= 1'b0;
            clko_reg <= 1'b0;
            div_reg <= 1'b0;
        end
        else
        begin
            acc_reg <= acc_next;
            program_counter_reg <= pc_next;
            status_word_reg <= status_next;
            stack_pointer_reg <= sp_next;
            upper_bank_flag_reg <= ubf_next;
            ext_irq_enable_flag_reg <= ext_next;
            counter_irq_enable_flag_reg <= cnt_en_next;
            insvc_reg <= insvc_next;
            p1_reg <= p1_next;
            p2_reg <= p2_next;
            bus_reg <= bus_next;
            bus_oe_reg <= bus_oe_next;
            clko_reg <= clko_next;
            div_reg <= !div_reg;
        end
    end

    // Counter
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            run_reg <= 1'b0;
            evt_reg <= 1'b0;
            timer_reg <= 8'h00;
            presc_reg <= 12'h000;
            timer_overflow_flag_reg <= 1'b0;
            pend_reg <= 1'b0;
            t1_prev_reg <= 1'b0;
        end
        else
        begin
            run_reg <= run_next;
            evt_reg <= evt_next;
            timer_reg <= timer_next;
            presc_reg <= presc_next;
            timer_overflow_flag_reg <= tof_next;
            pend_reg <= pend_next;
            t1_prev_reg <= test_input_one;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_start_short;
        first && !two_cycle;
    endsequence
    sequence s_start_long;
        first && two_cycle;
    endsequence

    a_idle_timing: assert property (
        s_start_short |=> state_reg == ST_DONE)
        else $error("one-cycle op did not finish in one cycle");
    a_long_timing: assert property (
        s_start_long |=> exec ##1 state_reg == ST_DONE)
        else $error("two-cycle op did not finish in two cycles");
    a_call_push: assert property (
        exec && is_call |=> stack_pointer_reg == $past(stack_pointer_reg)
        + 3'd1 && program_counter_reg[11] == $past(upper_bank_flag_reg))
        else $error("call push or bank bit wrong");
    a_pop_keeps: assert property (
        exec && op_reg == OP_POP_ONLY |=> status_word_reg
        == $past(status_word_reg) && insvc_reg == $past(insvc_reg))
        else $error("plain pop changed flags");
    a_popf_irq: assert property (
        exec && op_reg == OP_POP_FLAGS |=> !insvc_reg
        && stack_pointer_reg == $past(stack_pointer_reg) - 3'd1)
        else $error("flag pop did not release interrupts");
    a_port_out: assert property (
        exec && is_p_out && psel == 2'd1 |=> port1_drv.out == $past(acc_reg)
        && port1_drv.oe == ~$past(acc_reg))
        else $error("port 1 latch wrong");
    a_bus_out: assert property (
        exec && op_reg == OP_BUS_OUT |=> bus_oe && bus_out == $past(acc_reg))
        else $error("bus latch wrong");
    a_nib_read: assert property (
        exec && grp == GRP_N_IN |=> acc_reg == {4'h0, $past(exp_in)})
        else $error("nibble read wrong");
    a_nib_strobe: assert property (
        first && is_nib |-> exp_strobe ##1 !exp_strobe)
        else $error("expander strobe not one cycle");
    a_halt_count: assert property (
        exec && op_reg == OP_HALT |=> !run_reg ##1 $stable(timer_reg))
        else $error("counter still running after halt");
    a_tof_clear: assert property (
        exec && op_reg == OP_JUMP_TOF && !overflow
        |=> !timer_overflow_flag_reg)
        else $error("overflow flag not cleared by jump");
    a_pend_clear: assert property (
        exec && op_reg == OP_CNT_OFF && !overflow |=> !counter_irq
        && timer_overflow_flag_reg == $past(timer_overflow_flag_reg))
        else $error("counter irq disable wrong");
endmodule
`default_nettype wire

// File: mcu_far_side_model.sv
`timescale 1ns/10ps
`default_nettype none
module mcu_far_side_model
    import mcu_decode_pkg::*;
(
    input wire logic clk,
    input wire mcu_decode_pkg::qport_s port1_drv,
    input wire mcu_decode_pkg::qport_s port2_drv,
    input wire logic [7:0] ext1,
    input wire logic [7:0] ext2,
    input wire logic [7:0] bus_out,
    input wire logic bus_oe,
    input wire logic [7:0] bus_ext,
    input wire logic [3:0] exp_out,
    input wire logic [1:0] exp_cmd,
    input wire logic [1:0] exp_port,
    input wire logic exp_strobe,
    output logic [7:0] port1_in,
    output logic [7:0] port2_in,
    output logic [7:0] bus_in,
    output logic [3:0] exp_in
);
    logic [3:0] nib_reg [4];
    logic hold_reg;
    wire logic [3:0] nib = nib_reg[exp_port];
    // Weak high pin, pulled low by either side
    assign port1_in = port1_drv.out & ext1;
    assign port2_in = port2_drv.out & ext2;
    // Released bus shows the peripheral's data
    assign bus_in = bus_oe ? bus_out : bus_ext;
    // Nibble shown during any strobe and the cycle after a read strobe, inverted otherwise
    assign exp_in = (exp_strobe || hold_reg) ? nib : ~nib;
    initial
    begin
        nib_reg = '{4'h0, 4'h0, 4'h0, 4'h0};
        hold_reg = 1'b0;
    end
    always @(posedge clk)
    begin
        hold_reg <= exp_strobe && exp_cmd == EXP_READ;
        if (exp_strobe)
        begin
            case (exp_cmd)
                EXP_WRITE: nib_reg[exp_port] <= exp_out;
                EXP_OR: nib_reg[exp_port] <= nib | exp_out;
                EXP_AND: nib_reg[exp_port] <= nib & exp_out;
                default: ;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: mcu_call_io_timer_decode_test.sv
`timescale 1ns/10ps
`default_nettype none
module mcu_call_io_timer_decode_test
    import mcu_decode_pkg::*;
;
    logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, bus_oe;
    logic exp_strobe, test_input_zero_out, test_input_zero_oe, reg_bank;
    logic test_input_one, counter_irq, ext_irq_enable, irq_blocked;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [7:0] port1_in, port2_in, bus_in, bus_out, ext1, ext2, bus_ext;
    logic [3:0] exp_in, exp_out;
    logic [1:0] exp_cmd, exp_port;
    qport_s port1_drv, port2_drv;
    int bad_count, check_count, seed, acc, pc, i, j, k, cf, hf;
    int stk[$];
    int btab[4] = '{0, 'h10, 'h10, 'h110};

    mcu_call_io_timer_decode mcu_call_io_timer_decode_i (.clk, .sys_rst,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .port1_in, .port1_drv, .port2_in, .port2_drv,
        .bus_in, .bus_out, .bus_oe, .exp_in, .exp_out, .exp_cmd, .exp_port,
        .exp_strobe, .test_input_zero_out, .test_input_zero_oe,
        .test_input_one, .counter_irq, .ext_irq_enable, .reg_bank,
        .irq_blocked);
    mcu_far_side_model mcu_far_side_model_i (.clk, .port1_drv, .port2_drv,
        .ext1, .ext2, .bus_out, .bus_oe, .bus_ext, .exp_out, .exp_cmd,
        .exp_port, .exp_strobe, .port1_in, .port2_in, .bus_in, .exp_in);

    task automatic close_out();
    begin
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    end
    endtask

    task automatic xfer(input logic w, input logic [2:0] ix,
                        input logic [31:0] d);
    begin
        @(posedge clk);
        avs_address <= {ix, 2'b00};
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        q = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
    end
    endtask

    task automatic rdm(input logic [2:0] ix, input logic [31:0] m,
                       input logic [31:0] e);
    begin
        xfer(0, ix, 0);
        chk(q & m, e);
    end
    endtask

    task automatic ex(input logic [7:0] op, input logic [7:0] im, input int n);
    begin
        xfer(1, IDX_CMD, {16'h0, im, op});
        pc = (pc + n) % 4096;
    end
    endtask

    task automatic wr_acc(input int v);
    begin
        acc = v;
        xfer(1, IDX_ACC, 32'(v));
    end
    endtask

    task automatic pulse();
    begin
        test_input_one <= 1;
        repeat (300) @(posedge clk);
        test_input_one <= 0;
        repeat (300) @(posedge clk);
    end
    endtask

    initial
    begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        bad_count++;
        close_out();
    end

    initial
    begin
        seed = 32'h74fe8acd;
        sys_rst = 1;
        {avs_read, avs_write, test_input_one, avs_address, avs_writedata} = '0;
        {ext1, ext2, bus_ext} = '0;
        repeat (3) @(posedge clk);
        sys_rst <= 0;
        rdm(IDX_STATUS, '1, 'h08);
        xfer(1, 3'h6, '1);
        rdm(3'h6, '1, 0);
        for (i = 0; i < 6; i++)
        begin
            wr_acc($random(seed) & 255);
            j = $random(seed) & 255;
            ex(i % 2 ? 8'h13 : 8'h03, 8'(j), 2);
            k = acc + j + (i % 2) * cf;
            hf = (acc % 16 + j % 16 + (i % 2) * cf) > 15;
            cf = k > 255;
            rdm(IDX_ACC, '1, k % 256);
            rdm(IDX_STATUS, 'hc0, cf * 128 + hf * 64);
        end
        wr_acc('h9b);
        ex(8'h57, 0, 1);
        rdm(IDX_ACC, '1, 1);
        rdm(IDX_STATUS, 'hc0, 'hc0);
        for (i = 0; i < 3; i++)
        begin
            wr_acc($random(seed) & 255);
            ex(i ? 8'(8'h38 + i) : 8'h02, 0, 1);
            j = $random(seed) & 255;
            ex(8'(8'h98 + i), 8'(j), 2);
            k = $random(seed) & 255;
            ex(8'(8'h88 + i), 8'(k), 2);
            chk(i == 0 ? bus_out : i == 1 ? port1_drv.out : port2_drv.out,
                (acc & j) | k);
            wr_acc(255);
            ex(i ? 8'(8'h38 + i) : 8'h02, 0, 1);
            {ext1, ext2, bus_ext} <= 24'($random(seed));
            ex(8'(8'h08 + i), 0, 1);
            rdm(IDX_ACC, '1, i == 0 ? bus_ext : i == 1 ? ext1 : ext2);
        end
        for (i = 0; i < 4; i++)
        begin
            wr_acc($random(seed) & 255);
            ex(8'(8'h3c + i), 0, 1);
            k = acc;
            wr_acc($random(seed) & 255);
            ex(8'(8'h8c + i), 0, 1);
            k = k | acc;
            wr_acc($random(seed) & 255);
            ex(8'(8'h9c + i), 0, 1);
            ex(8'(8'h0c + i), 0, 1);
            rdm(IDX_ACC, '1, k & acc & 15);
        end
        xfer(1, IDX_STATUS, 32'h10050);
        ex(8'hf5, 0, 1);
        ex(8'h34, 8'h21, 2);
        stk.push_back(pc);
        pc = 'h921;
        rdm(IDX_PROG, '1, pc);
        rdm(IDX_STATUS, 'hff, 'h59);
        xfer(1, IDX_STATUS, 32'h10000);
        ex(8'he5, 0, 1);
        ex(8'hf4, 8'h7f, 2);
        stk.push_back(pc);
        pc = 'h77f;
        rdm(IDX_PROG, '1, pc);
        ex(8'h83, 0, 1);
        pc = stk.pop_back();
        rdm(IDX_PROG, '1, pc);
        rdm(IDX_STATUS, 'h100ff, 'h10009);
        ex(8'h93, 0, 1);
        pc = stk.pop_back();
        rdm(IDX_PROG, '1, pc);
        rdm(IDX_STATUS, 'h100ff, 'h58);
        for (i = 0; i < 4; i++)
        begin
            ex(8'(8'hc5 + 16 * i), 0, 1);
            rdm(IDX_STATUS, 'h110, btab[i]);
        end
        ex(8'h00, 0, 1);
        rdm(IDX_PROG, '1, pc);
        ex(8'h75, 0, 1);
        chk(test_input_zero_oe, 1);
        k = test_input_zero_out;
        @(posedge clk);
        chk(test_input_zero_out, !k);
        wr_acc('hfe);
        ex(8'h62, 0, 1);
        ex(8'h25, 0, 1);
        ex(8'h45, 0, 1);
        repeat (3) pulse();
        ex(8'h42, 0, 1);
        rdm(IDX_ACC, '1, 1);
        rdm(IDX_STATUS, 'h1800, 'h1800);
        chk(counter_irq, 1);
        ex(8'h35, 0, 1);
        chk(counter_irq, 0);
        rdm(IDX_STATUS, 'h1c00, 'h800);
        ex(8'h65, 0, 1);
        pulse();
        ex(8'h42, 0, 1);
        rdm(IDX_ACC, '1, 1);
        ex(8'h16, 0, 2);
        pc = pc / 256 * 256;
        rdm(IDX_PROG, '1, pc);
        rdm(IDX_STATUS, 'h800, 0);
        wr_acc(0);
        ex(8'h62, 0, 1);
        ex(8'h55, 0, 1);
        repeat (2 * TIMER_TICK_CYCLES + 100) @(posedge clk);
        ex(8'h65, 0, 1);
        ex(8'h42, 0, 1);
        rdm(IDX_ACC, '1, 2);
        close_out();
    end
endmodule
`default_nettype wire
